// ===== logic/esd_exception_unit.sv
// exception sequencing, service sequence and debug trap logic
//
// Behaviour
// [RULE1] overflow trap: save status, clear T V U S P, vector 13, return to next
// [RULE2] debug condition taken at instruction boundary or interruptible point
// [RULE3] debug trap vector 14; string restart address; clear T V U S P I
// [RULE4] fatal bus error vector 12, undefined return, dummy slave status read
// [RULE5] exception before instruction end clears P in the saved copy; a fatal bus error taken mid-instruction keeps P there
// [RULE6] push saved status 16 bit, then module pointer unless direct mode
// [RULE7] read 32 bit entry at dispatch base plus vector times four
// [RULE8] direct mode loads whole entry into program counter
// [RULE9] modular mode loads module, program base plus offset, static base
// [RULE10] push return address 32 bit, then non-sequential handler fetch
// [RULE11] service memory accesses may be reordered
// [RULE12] T copied to P at instruction start; P at end raises trace trap
// [RULE13] other service completes first; one trace trap per instruction
// [RULE14] trace during wait deferred until interrupt handler returns
// [RULE15] address compare with byte, read, write and master enables
// [RULE16] compare applies to data, ack, end-of-interrupt and exception references
// [RULE17] pc match against breakpoint pc when enabled
// [RULE18] user, supervisor and global enables gate compare and pc match
// [RULE19] trap enable gates compare and match; external always traps; cause kept
// [RULE20] breakpoint output at next instruction start with flow strobe
// [RULE21] cross-space moves compare user reference under user enable
// [RULE22] trace trap clears P, saves, clears T V U S, vector 9
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
module esd_exception_unit
    import esd_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic instr_start,
    input wire logic instr_end,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] next_addr,
    input wire logic interrupt_point,
    input wire logic in_wait,
    input wire logic interrupt_return,
    input wire logic ovf_detect,
    input wire logic fatal_bus_error,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [3:0] acc_be,
    input wire logic acc_user_space,
    input wire logic external_debug_input_n,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_half,
    output logic mem_fetch,
    output logic busy,
    output logic program_flow_strobe_n,
    output logic breakpoint_output_n
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    esd_state_type state_reg, state_next;
    logic [15:0] psr_reg, psr_copy_reg, psr_next_copy;
    logic [15:0] mod_reg;
    logic [31:0] base_reg, sb_reg, car_reg, dcr_reg, bpc_reg, isp_reg, pc_reg;
    logic [2:0] dsr_reg;
    logic [7:0] vec_reg;
    logic [31:0] ret_reg, entry_reg;
    logic ovf_pend, nrbe_pend, trc_pend, wait_trc;
    logic dbg_ac, dbg_pc, dbg_ext, bp_pend;
    logic dbg_sync1, dbg_sync2, ext_prev;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction : sel

    wire mode_en = dcr_reg[DCR_DEN] &&
        (psr_reg[PSR_U] ? dcr_reg[DCR_UD] : dcr_reg[DCR_SD]); // see [RULE18]
    wire user_ref = acc_user_space || psr_reg[PSR_U];
    wire acc_mode_en = dcr_reg[DCR_DEN] &&
        (user_ref ? dcr_reg[DCR_UD] : dcr_reg[DCR_SD]); // see [RULE21]
    wire own_ref = mem_req && mem_ack;
    wire cmp_valid = acc_valid || own_ref; // see [RULE16]
    wire cmp_write = acc_valid ? acc_write : mem_we;
    wire [31:0] cmp_addr = acc_valid ? acc_addr : mem_addr;
    wire [3:0] cmp_be = acc_valid ? acc_be : 4'hF;
    wire cmp_en = acc_valid ? acc_mode_en : (dcr_reg[DCR_DEN] && dcr_reg[DCR_SD]);
    wire ac_hit = cmp_valid && cmp_en && dcr_reg[DCR_CAE] &&
        (cmp_addr[31:2] == car_reg[31:2]) &&
        ((cmp_be & dcr_reg[DCR_CBE_LO +: 4]) != 4'h0) &&
        (cmp_write ? dcr_reg[DCR_WR] : dcr_reg[DCR_RD]); // see [RULE15]
    wire pc_hit = instr_start && mode_en && dcr_reg[DCR_PCE] &&
        (instr_addr == bpc_reg); // see [RULE17]
    wire ext_now = !dbg_sync2;
    wire ext_edge = ext_now && !ext_prev;
    wire tr_en = dcr_reg[DCR_TR];
    wire idle = (state_reg == ST_IDLE);
    wire boundary = idle && !instr_start && !instr_end;
    // string restart point allows compare and external, not pc match
    wire dbg_mid = interrupt_point && (dbg_ac || dbg_ext); // see [RULE2]
    wire take_nrbe = idle && nrbe_pend;
    wire take_ovf = boundary && !nrbe_pend && ovf_pend;
    wire take_dbg = idle && !nrbe_pend && !ovf_pend &&
        ((boundary && (dbg_ac || dbg_pc || dbg_ext)) || dbg_mid);
    wire take_trc = boundary && !nrbe_pend && !ovf_pend && !take_dbg && trc_pend;
    wire take_any = take_nrbe || take_ovf || take_dbg || take_trc;
    wire direct = dcr_reg[DCR_DIRECT];
    wire acc_done = mem_req && mem_ack;
    wire psr_sel = sel(reg_addr, ADDR_PSR);

    // ------------------------------------------------------------
    // service sequence
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take_nrbe) begin
                    state_next = ST_DUMMY; // see [RULE4]
                end else if (take_any) begin
                    state_next = ST_PUSH_PSR;
                end
            end
            ST_DUMMY: if (acc_done) state_next = ST_PUSH_PSR;
            ST_PUSH_PSR: if (acc_done) state_next = direct ? ST_ENTRY : ST_PUSH_MOD;
            ST_PUSH_MOD: if (acc_done) state_next = ST_ENTRY;
            ST_ENTRY: if (acc_done) state_next = direct ? ST_PUSH_RET : ST_PBASE;
            ST_PBASE: if (acc_done) state_next = ST_SBASE;
            ST_SBASE: if (acc_done) state_next = ST_PUSH_RET;
            ST_PUSH_RET: if (acc_done) state_next = ST_FETCH;
            ST_FETCH: if (acc_done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // request set on entry to the first access state, held across states, dropped after the fetch acknowledge
    // accesses run in listed order; reordering is permitted but unused (see [RULE11])
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= WORD_RESET;
            mem_wdata <= WORD_RESET;
            mem_half <= 1'b0;
            mem_fetch <= 1'b0;
        end else begin
            state_reg <= state_next;
            mem_req <= (state_next != ST_IDLE) && ((state_next != state_reg) || mem_req);
            if (state_next != state_reg) begin
                mem_we <= 1'b0;
                mem_half <= 1'b0;
                mem_fetch <= 1'b0;
                unique case (state_next)
                    ST_DUMMY: mem_addr <= SLAVE_STATUS_ADDR; // see [RULE4]
                    ST_PUSH_PSR: begin
                        mem_we <= 1'b1;
                        mem_half <= 1'b1;
                        mem_addr <= isp_reg - HALF_BYTES;
                        mem_wdata <= {16'h0000, take_any ? psr_next_copy : psr_copy_reg};
                    end
                    ST_PUSH_MOD: begin
                        mem_we <= 1'b1;
                        mem_half <= 1'b1;
                        // stack pointer drops for the status push at this same edge
                        mem_addr <= isp_reg - HALF_BYTES - HALF_BYTES;
                        mem_wdata <= {16'h0000, mod_reg}; // see [RULE6]
                    end
                    ST_ENTRY: mem_addr <= base_reg + {vec_reg, 2'b00}; // see [RULE7]
                    ST_PBASE: mem_addr <= {16'h0000, mem_rdata[15:0]} + PB_OFFSET;
                    ST_SBASE: mem_addr <= {16'h0000, mod_reg}; // see [RULE9]
                    ST_PUSH_RET: begin
                        mem_we <= 1'b1;
                        mem_addr <= isp_reg - WORD_BYTES;
                        mem_wdata <= ret_reg; // see [RULE10]
                    end
                    ST_FETCH: begin
                        mem_fetch <= 1'b1; // see [RULE10]
                        mem_addr <= pc_reg;
                    end
                    default: mem_addr <= mem_addr;
                endcase
            end
        end
    end

    // saved status: P dropped for a debug trap at an interruptible point or for trace, kept for a fatal bus error
    always_comb begin
        psr_next_copy = psr_reg;
        if (take_trc || (take_dbg && dbg_mid)) begin
            psr_next_copy[PSR_P] = 1'b0; // see [RULE5] see [RULE22]
        end
    end

    // ------------------------------------------------------------
    // pointers loaded by the service sequence
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            isp_reg <= ISP_RESET;
            pc_reg <= WORD_RESET;
            mod_reg <= 16'h0000;
            sb_reg <= WORD_RESET;
            entry_reg <= WORD_RESET;
        end else begin
            if (acc_done && mem_half) isp_reg <= isp_reg - HALF_BYTES; // see [RULE6]
            else if (acc_done && state_reg == ST_PUSH_RET) isp_reg <= isp_reg - WORD_BYTES;
            else if (reg_write && sel(reg_addr, ADDR_ISP)) isp_reg <= reg_wdata;
            if (acc_done && state_reg == ST_ENTRY) begin
                entry_reg <= mem_rdata;
                if (direct) pc_reg <= mem_rdata; // see [RULE8]
                else mod_reg <= mem_rdata[15:0]; // see [RULE9]
            end else if (reg_write && sel(reg_addr, ADDR_MOD)) begin
                mod_reg <= reg_wdata[15:0];
            end
            if (acc_done && state_reg == ST_PBASE) begin
                pc_reg <= mem_rdata + {16'h0000, entry_reg[31:16]}; // see [RULE9]
            end
            if (acc_done && state_reg == ST_SBASE) sb_reg <= mem_rdata; // see [RULE9]
            else if (reg_write && sel(reg_addr, ADDR_SB)) sb_reg <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // exception entry: vector, return address, status word
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            psr_reg <= PSR_RESET;
            psr_copy_reg <= PSR_RESET;
            vec_reg <= 8'h00;
            ret_reg <= WORD_RESET;
        end else if (take_any) begin
            psr_copy_reg <= psr_next_copy;
            if (take_nrbe) begin
                vec_reg <= VEC_NRBE; // see [RULE4]
                ret_reg <= WORD_RESET;
                psr_reg <= psr_reg & ~CLR_TVUSPI;
            end else if (take_ovf) begin
                vec_reg <= VEC_OVF; // see [RULE1]
                ret_reg <= next_addr;
                psr_reg <= psr_reg & ~CLR_TVUSP;
            end else if (take_dbg) begin
                vec_reg <= VEC_DBG; // see [RULE3]
                ret_reg <= (dbg_mid && !dbg_pc) ? instr_addr : next_addr;
                psr_reg <= psr_reg & ~CLR_TVUSPI;
            end else begin
                vec_reg <= VEC_TRC; // see [RULE22]
                ret_reg <= next_addr;
                psr_reg <= psr_reg & ~CLR_TVUS & ~(16'h0001 << PSR_P);
            end
        end else if (instr_start) begin
            psr_reg[PSR_P] <= psr_reg[PSR_T]; // see [RULE12]
        end else if (reg_write && psr_sel) begin
            psr_reg <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // pending exceptions
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ovf_pend <= 1'b0;
            nrbe_pend <= 1'b0;
            trc_pend <= 1'b0;
            wait_trc <= 1'b0;
        end else begin
            nrbe_pend <= fatal_bus_error || (nrbe_pend && !take_nrbe);
            ovf_pend <= (instr_end && ovf_detect) || (ovf_pend && !take_ovf);
            // trace waits behind every other pending service
            if (instr_end && psr_reg[PSR_P] && !in_wait) begin
                trc_pend <= 1'b1; // see [RULE12] see [RULE13]
            end else if (interrupt_return && wait_trc) begin
                trc_pend <= 1'b1; // see [RULE14]
            end else if (take_any || instr_start) begin
                // another service takes over; its saved P brings the trace back later
                trc_pend <= 1'b0; // see [RULE13]
            end
            if (instr_end && psr_reg[PSR_P] && in_wait) wait_trc <= 1'b1; // see [RULE14]
            else if (interrupt_return) wait_trc <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // debug conditions and breakpoint pin
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            dbg_sync1 <= 1'b1;
            dbg_sync2 <= 1'b1;
            ext_prev <= 1'b0;
            dbg_ac <= 1'b0;
            dbg_pc <= 1'b0;
            dbg_ext <= 1'b0;
            bp_pend <= 1'b0;
            program_flow_strobe_n <= 1'b1;
            breakpoint_output_n <= 1'b1;
        end else begin
            dbg_sync1 <= external_debug_input_n;
            dbg_sync2 <= dbg_sync1;
            ext_prev <= ext_now;
            dbg_ac <= (ac_hit && tr_en) || (dbg_ac && !take_dbg); // see [RULE19]
            dbg_pc <= (pc_hit && tr_en) || (dbg_pc && !take_dbg); // see [RULE19]
            dbg_ext <= ext_edge || (dbg_ext && !take_dbg); // see [RULE19]
            program_flow_strobe_n <= !instr_start;
            breakpoint_output_n <= !(instr_start && bp_pend); // see [RULE20]
            bp_pend <= ac_hit || pc_hit || (bp_pend && !instr_start); // see [RULE20]
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            base_reg <= WORD_RESET;
            car_reg <= WORD_RESET;
            dcr_reg <= WORD_RESET;
            bpc_reg <= WORD_RESET;
            dsr_reg <= 3'b000;
        end else begin
            if (reg_write && sel(reg_addr, ADDR_BASE)) base_reg <= reg_wdata;
            if (reg_write && sel(reg_addr, ADDR_CAR)) car_reg <= reg_wdata;
            if (reg_write && sel(reg_addr, ADDR_DCR)) dcr_reg <= reg_wdata;
            if (reg_write && sel(reg_addr, ADDR_BPC)) bpc_reg <= reg_wdata;
            // cause recorded on taking the trap; the set wins over a clear
            if (take_dbg) begin
                dsr_reg <= {dbg_ext, dbg_pc, dbg_ac}; // see [RULE19]
            end else if (reg_write && sel(reg_addr, ADDR_DSR)) begin
                dsr_reg <= dsr_reg & ~reg_wdata[2:0];
            end
        end
    end

    wire [31:0] rd_mux =
        psr_sel ? {16'h0000, psr_reg} :
        sel(reg_addr, ADDR_MOD) ? {16'h0000, mod_reg} :
        sel(reg_addr, ADDR_BASE) ? base_reg :
        sel(reg_addr, ADDR_SB) ? sb_reg :
        sel(reg_addr, ADDR_CAR) ? car_reg :
        sel(reg_addr, ADDR_DCR) ? dcr_reg :
        sel(reg_addr, ADDR_BPC) ? bpc_reg :
        sel(reg_addr, ADDR_DSR) ? {29'h0000_0000, dsr_reg} :
        sel(reg_addr, ADDR_ISP) ? isp_reg :
        sel(reg_addr, ADDR_PC) ? pc_reg : WORD_RESET;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= WORD_RESET;
            busy <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : WORD_RESET;
            busy <= !idle || take_any || ovf_pend || nrbe_pend || trc_pend;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ovf_vector_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE1]
        take_ovf |=> vec_reg == VEC_OVF && ret_reg == $past(next_addr) &&
            psr_reg[PSR_T] == 1'b0 && psr_reg[PSR_P] == 1'b0)
        else $error("overflow trap entry wrong");
    dbg_entry_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE3]
        take_dbg |=> vec_reg == VEC_DBG && psr_reg[PSR_I] == 1'b0 &&
            psr_reg[PSR_U] == 1'b0)
        else $error("debug trap entry wrong");
    nrbe_dummy_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE4]
        take_nrbe |=> vec_reg == VEC_NRBE && mem_req && mem_addr == SLAVE_STATUS_ADDR)
        else $error("fatal bus error entry wrong");
    mid_copy_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE5]
        (take_dbg && dbg_mid) |=> psr_copy_reg[PSR_P] == 1'b0)
        else $error("saved P not cleared");
    entry_addr_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE7]
        (state_reg == ST_ENTRY && mem_req) |-> mem_addr == base_reg + ENTRY_BYTES * vec_reg)
        else $error("dispatch entry address wrong");
    direct_pc_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE8]
        (state_reg == ST_ENTRY && acc_done && direct) |=>
            pc_reg == $past(mem_rdata) && state_reg == ST_PUSH_RET)
        else $error("direct mode pc load wrong");
    ret_push_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE10]
        (state_reg == ST_PUSH_RET && acc_done) |=> state_reg == ST_FETCH && mem_fetch
            && mem_addr == pc_reg ##1 !mem_we)
        else $error("handler fetch missing");
    trace_copy_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE12]
        (instr_start && !take_any) |=> psr_reg[PSR_P] == $past(psr_reg[PSR_T]))
        else $error("trace pending copy wrong");
    bp_align_a: assert property (@(posedge clock) disable iff (!resetn) // see [RULE20]
        !breakpoint_output_n |-> !program_flow_strobe_n)
        else $error("breakpoint not aligned with flow strobe");
endmodule : esd_exception_unit

// ===== logic/esd_pkg.sv
// constants, field layout and state codes of the exception and debug unit
package esd_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PSR = 8'h00;
    localparam logic [7:0] ADDR_MOD = 8'h04;
    localparam logic [7:0] ADDR_BASE = 8'h08;
    localparam logic [7:0] ADDR_SB = 8'h0C;
    localparam logic [7:0] ADDR_CAR = 8'h10;
    localparam logic [7:0] ADDR_DCR = 8'h14;
    localparam logic [7:0] ADDR_BPC = 8'h18;
    localparam logic [7:0] ADDR_DSR = 8'h1C;
    localparam logic [7:0] ADDR_ISP = 8'h20;
    localparam logic [7:0] ADDR_PC = 8'h24;
    // ------------------------------------------------------------
    // status word bits
    // ------------------------------------------------------------
    localparam int PSR_T = 1;
    localparam int PSR_V = 4;
    localparam int PSR_U = 8;
    localparam int PSR_S = 9;
    localparam int PSR_P = 10;
    localparam int PSR_I = 11;
    localparam logic [15:0] CLR_TVUS = 16'h0312;
    localparam logic [15:0] CLR_TVUSP = 16'h0712;
    localparam logic [15:0] CLR_TVUSPI = 16'h0F12;
    // ------------------------------------------------------------
    // debug control and status fields
    // ------------------------------------------------------------
    localparam int DCR_CBE_LO = 0;
    localparam int DCR_RD = 4;
    localparam int DCR_WR = 5;
    localparam int DCR_CAE = 6;
    localparam int DCR_PCE = 7;
    localparam int DCR_UD = 8;
    localparam int DCR_SD = 9;
    localparam int DCR_DEN = 10;
    localparam int DCR_TR = 11;
    localparam int DCR_DIRECT = 16;
    localparam int DSR_AC = 0;
    localparam int DSR_PC = 1;
    localparam int DSR_EXT = 2;
    // ------------------------------------------------------------
    // vectors, sizes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_TRC = 8'h09;
    localparam logic [7:0] VEC_NRBE = 8'h0C;
    localparam logic [7:0] VEC_OVF = 8'h0D;
    localparam logic [7:0] VEC_DBG = 8'h0E;
    localparam logic [31:0] ENTRY_BYTES = 32'h0000_0004;
    localparam logic [31:0] PB_OFFSET = 32'h0000_0008;
    localparam logic [31:0] HALF_BYTES = 32'h0000_0002;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [31:0] SLAVE_STATUS_ADDR = 32'hFFFF_FE10;
    localparam logic [15:0] PSR_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] ISP_RESET = 32'h0000_1000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_DUMMY = 4'b0001,
        ST_PUSH_PSR = 4'b0010,
        ST_PUSH_MOD = 4'b0011,
        ST_ENTRY = 4'b0100,
        ST_PBASE = 4'b0101,
        ST_SBASE = 4'b0110,
        ST_PUSH_RET = 4'b0111,
        ST_FETCH = 4'b1000
    } esd_state_type;
endpackage : esd_pkg

// ===== sim/esd_mem_model.sv
// memory bus responder with varying acknowledge latency
`timescale 1ns/1ns
module esd_mem_model(
    input wire logic clock,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    int lat = 0;
    int cnt = 0;
    initial begin
        mem_ack = 0;
        mem_rdata = 0;
    end
    // data toggles when not answering so stale values never look valid
    always @(posedge clock) begin
        mem_ack <= 0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (cnt >= lat) begin
                mem_ack <= 1;
                mem_rdata <= {mem_addr[15:0], mem_addr[31:16]} ^ 32'h3c3c_a5a5;
                cnt <= 0;
                lat <= (lat + 1) % 3;
            end else cnt <= cnt + 1;
        end
    end
endmodule : esd_mem_model

// ===== sim/esd_exception_unit_bench.sv
// self-checking bench of the exception and debug unit
`timescale 1ns/1ns
module esd_exception_unit_bench;
    import esd_pkg::*;
    logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, instr_start = 0, instr_end = 0;
    logic ovf_detect = 0, fatal_bus_error = 0, acc_valid = 0, acc_write = 0, interrupt_point = 0;
    logic mem_ack, mem_req, mem_we, mem_half, mem_fetch, busy;
    logic program_flow_strobe_n, breakpoint_output_n;
    logic [7:0] reg_addr = 0;
    logic [3:0] acc_be = 0;
    logic [31:0] reg_wdata = 0, next_addr = 0, instr_addr = 0, acc_addr = 0;
    logic [31:0] reg_rdata, mem_rdata, mem_addr, mem_wdata;
    logic [66:0] seen[$], exp_q[$];
    int n_mismatch = 0, n_compared = 0, seed = 32'ha543;
    esd_exception_unit i_dut(.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .instr_start, .instr_end, .instr_addr, .next_addr, .interrupt_point,
        .in_wait(1'b0), .interrupt_return(1'b0), .ovf_detect, .fatal_bus_error, .acc_valid,
        .acc_write, .acc_addr, .acc_be, .acc_user_space(1'b0), .external_debug_input_n(1'b1),
        .mem_rdata, .mem_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_half,
        .mem_fetch, .busy, .program_flow_strobe_n, .breakpoint_output_n);
    esd_mem_model i_mem(.clock, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    initial forever #2 clock = ~clock;
    always @(posedge clock) if (mem_req && mem_ack) seen.push_back({mem_we, mem_half & mem_we,
        mem_fetch, mem_addr, !mem_we ? 32'h0 : mem_half ? {16'h0, mem_wdata[15:0]} : mem_wdata});
    function logic [31:0] f(input logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'h3c3c_a5a5;
    endfunction : f
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [66:0] e, input logic [66:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_write <= 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clock);
        reg_read <= 1; reg_addr <= a;
        @(posedge clock);
        reg_read <= 0;
        #1 chk(nm, {35'h0, e}, {35'h0, reg_rdata});
    endtask : rd
    // k: 0 overflow, 1 fatal bus error, 2 address-compare debug, 3 same at a string stop
    task run(input int k, input logic dir);
        logic [15:0] processor_status_word;
        logic [31:0] e, mp, ret, sp, pc, va;
        int n;
        processor_status_word = $random(seed) & 16'h0F12;
        processor_status_word[PSR_P] = processor_status_word[PSR_T];
        if (k == 1) processor_status_word = processor_status_word & 16'h0B10;
        va = 32'h4000 + 4 * (k == 0 ? VEC_OVF : k == 1 ? VEC_NRBE : VEC_DBG);
        ret = k == 1 ? 0 : $random(seed);
        mp = ($random(seed) & 32'h0000_7ffc) | 32'h0000_8000;
        wr(ADDR_PSR, processor_status_word); wr(ADDR_ISP, 32'h0000_2000); wr(ADDR_BASE, 32'h0000_4000);
        wr(ADDR_MOD, mp); wr(ADDR_CAR, 32'h0000_0100);
        wr(ADDR_DCR, {15'h0, dir, k >= 2 ? 16'h0F7F : 16'h0});
        seen.delete(); exp_q.delete();
        @(posedge clock);
        instr_start <= 1; next_addr <= ret; instr_addr <= ret - 4;
        @(posedge clock);
        instr_start <= 0; acc_valid <= k >= 2; acc_addr <= 32'h0000_0102;
        acc_be <= 4'h4; acc_write <= $random(seed);
        @(posedge clock);
        acc_valid <= 0; instr_end <= k == 0 || k == 2; interrupt_point <= k == 3;
        ovf_detect <= k == 0; fatal_bus_error <= k == 1;
        @(posedge clock);
        instr_end <= 0; interrupt_point <= 0; ovf_detect <= 0; fatal_bus_error <= 0;
        repeat (3) @(posedge clock);
        for (n = 0; busy !== 1'b0 && n < 300; n++) @(posedge clock);
        if (n == 300) begin
            n_mismatch++;
            test_done;
        end
        instr_start <= 1;
        @(posedge clock);
        instr_start <= 0;
        #1 chk("flow strobe", 1, !program_flow_strobe_n);
        chk("breakpoint", k >= 2, !breakpoint_output_n);
        if (k == 3) processor_status_word[PSR_P] = 1'b0;
        sp = 32'h2000 - 2;
        if (k == 1) exp_q.push_back({3'b000, SLAVE_STATUS_ADDR, 32'h0});
        exp_q.push_back({3'b110, sp, 16'h0, processor_status_word});
        if (!dir) exp_q.push_back({3'b110, sp - 2, 16'h0, mp[15:0]});
        sp = dir ? sp - 4 : sp - 6;
        e = f(va);
        exp_q.push_back({3'b000, va, 32'h0});
        pc = dir ? e : f({16'h0, e[15:0]} + 8) + {16'h0, e[31:16]};
        if (!dir) exp_q.push_back({3'b000, {16'h0, e[15:0]} + 32'h8, 32'h0});
        if (!dir) exp_q.push_back({3'b000, 16'h0, e[15:0], 32'h0});
        exp_q.push_back({3'b100, sp, k == 3 ? ret - 4 : ret});
        exp_q.push_back({3'b001, pc, 32'h0});
        chk("access count", exp_q.size(), seen.size());
        for (int i = 0; i < exp_q.size() && i < seen.size(); i++)
            chk("access", exp_q[i], seen[i]);
        rd(ADDR_PSR, processor_status_word & ~(k == 0 ? CLR_TVUSP : CLR_TVUSPI), "status");
        rd(ADDR_MOD, dir ? mp : e[15:0], "module");
        rd(ADDR_DSR, k >= 2, "cause");
        wr(ADDR_DSR, 32'h0000_0007);
        $display("test kind %0d direct %0d done", k, dir);
    endtask : run
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1;
        rd(ADDR_ISP, ISP_RESET, "stack reset");
        rd(ADDR_PSR, 32'h0, "status reset");
        rd(8'h80, 32'h0, "unmapped");
        for (int i = 0; i < 5; i++) run(i < 2 ? 0 : i - 1, i == 0 || i == 3);
        test_done;
    end
endmodule : esd_exception_unit_bench
